// File: include/dss_pkg.sv
/*
 Package for the distributed-sample descrambler sync block: timing counts,
 generator taps and seed, buffer and verify sizes, and the sync state encoding.
 Assumes a single bit clock; one received bit per enabled cycle.
*/
`default_nettype none
package dss_pkg;
   // ****************************************
   // Timing, generator taps and sizes
   // ****************************************
   localparam int SAMPLE_DELAY_BITS = 211;
   localparam int CELL_BITS_DEFAULT = 424;
   localparam int PRBS_WIDTH = 31;
   localparam logic [30:0] PRBS_TAPS_DEFAULT = 31'h48000000;
   localparam logic [30:0] PRBS_SEED = 31'h00000001;
   localparam logic [30:0] FF_TAPS_DEFAULT = 31'h00000009;
   localparam int FIFO_DEPTH_DEFAULT = 4;
   localparam int VERIFY_TARGET = 8;
   // ****************************************
   // Sync states
   // ****************************************
   typedef enum logic [1:0] {
      DSS_HUNT = 2'b00,
      DSS_VERIFY = 2'b01,
      DSS_LOCKED = 2'b11
   } dss_state_t;
endpackage
`default_nettype wire

// File: src/dss_fifo.sv
/*
 Small synchronous FIFO with valid/ready on both sides.
 Assumes one clock and a synchronous active-low reset.
*/
`default_nettype none
module dss_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
         in_ready <= (count + (AW+1)'(push) - (AW+1)'(pop)) < (AW+1)'(DEPTH);
         out_valid <= (count + (AW+1)'(push) - (AW+1)'(pop)) != '0;
      end
   end

   // Read data is combinational off the stored word; mem itself is registered
   assign out_data = mem[rd_ptr];

   a_fifo_no_overflow: assert property (@(posedge sys_clk) disable iff (!rst_n)
      count <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule
`default_nettype wire

// File: src/dss_sync.sv
/*
 Receiver-side acquisition of distributed-sample scrambler sync.
 Extracts the two conveyed samples per cell from the header check bits,
 delay-equalises them and drives a recursive descrambler.
 Assumes the cell delineator marks check bit eight with bit_at_header_check_bit_eight and
 that rx_valid strobes each received bit; inputs synchronous to sys_clk.
*/
`default_nettype none
module dss_sync #(
   parameter int CELL_BITS = dss_pkg::CELL_BITS_DEFAULT,
   parameter logic [30:0] FF_TAPS = dss_pkg::FF_TAPS_DEFAULT,
   parameter logic [30:0] PRBS_TAPS = dss_pkg::PRBS_TAPS_DEFAULT,
   parameter int FIFO_DEPTH = dss_pkg::FIFO_DEPTH_DEFAULT
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Received bit stream
   input wire logic rx_valid,
   input wire logic rx_bit,
   input wire logic bit_at_header_check_bit_eight,
   // Predicted header check bits from the header generator
   input wire logic predicted_check_bit,
   // Descrambled output stream
   output logic dsc_valid,
   input wire logic dsc_ready,
   output logic dsc_bit,
   // Status
   output logic sync_locked,
   output logic stall
);
   localparam int D = dss_pkg::SAMPLE_DELAY_BITS;
   localparam int CW = $clog2(CELL_BITS + 1);

   // ****************************************
   // Bit position within the cell
   // ****************************************
   logic [CW-1:0] pos;
   logic [CW-1:0] next_pos;
   logic fifo_in_ready;
   logic step;

   // Back-pressure from the output FIFO freezes the whole receive pipeline
   assign step = rx_valid && fifo_in_ready;
   assign next_pos = bit_at_header_check_bit_eight ? CW'(1) :
                     (pos == CW'(CELL_BITS - 1)) ? '0 : pos + 1'b1;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pos <= '0;
      end else if (step) begin
         pos <= next_pos;
      end
   end

   logic at_t;
   logic at_t1;
   logic at_t212;
   logic at_t213;
   assign at_t = step && bit_at_header_check_bit_eight;
   assign at_t1 = step && !bit_at_header_check_bit_eight && pos == CW'(1);
   assign at_t212 = step && pos == CW'(D + 1);
   // Reload point follows the cell length, one cell minus the storage delay
   assign at_t213 = step && pos == CW'(CELL_BITS - D);

   // ****************************************
   // Local PRBS generator
   // ****************************************
   logic [30:0] prbs;
   logic local_sample;
   assign local_sample = prbs[30];

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         prbs <= dss_pkg::PRBS_SEED;
      end else if (step) begin
         prbs <= {prbs[29:0], ^(prbs & PRBS_TAPS)};
      end
   end

   // ****************************************
   // Sample extraction and delay flops
   // ****************************************
   logic conveyed;
   logic upper_sample_flop;
   logic lower_sample_flop;
   logic first_sample_xor;
   logic second_sample_xor;

   assign conveyed = rx_bit ^ predicted_check_bit;
   assign first_sample_xor = conveyed ^ lower_sample_flop;
   assign second_sample_xor = upper_sample_flop ^ lower_sample_flop;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         upper_sample_flop <= 1'b0;
         lower_sample_flop <= 1'b0;
      end else if (at_t1) begin
         upper_sample_flop <= conveyed;
         lower_sample_flop <= local_sample;
      end else if (at_t) begin
         upper_sample_flop <= conveyed;
      end else if (at_t213) begin
         lower_sample_flop <= local_sample;
      end
   end

   // ****************************************
   // Multiplexer into the recursive descrambler
   // ****************************************
   logic mux_valid;
   logic mux_bit;
   // Bit seven sample waits 211 bits so both enter at their source spacing
   assign mux_valid = at_t || at_t212;
   assign mux_bit = at_t ? first_sample_xor : second_sample_xor;

   // ****************************************
   // Recursive descrambler and verification
   // ****************************************
   logic [30:0] dsc;
   logic predicted_sample;
   logic predicted_hold;
   logic [3:0] match_count;
   dss_pkg::dss_state_t state;

   assign predicted_sample = ^(dsc & FF_TAPS);

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         dsc <= '0;
      end else if (mux_valid) begin
         dsc <= {dsc[29:0], mux_bit};
      end
   end

   // One-bit store lines the prediction up with the sample it checks
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         predicted_hold <= 1'b0;
      end else if (mux_valid) begin
         predicted_hold <= predicted_sample;
      end
   end

   logic verify_valid;
   logic verify_bit;
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         verify_valid <= 1'b0;
         verify_bit <= 1'b0;
      end else begin
         verify_valid <= mux_valid;
         verify_bit <= mux_bit;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state <= dss_pkg::DSS_HUNT;
         match_count <= '0;
      end else if (verify_valid) begin
         case (state)
            dss_pkg::DSS_HUNT: begin
               state <= dss_pkg::DSS_VERIFY;
               match_count <= '0;
            end
            dss_pkg::DSS_VERIFY: begin
               if (verify_bit != predicted_hold) begin
                  match_count <= '0;
               end else if (match_count == 4'(dss_pkg::VERIFY_TARGET - 1)) begin
                  state <= dss_pkg::DSS_LOCKED;
               end else begin
                  match_count <= match_count + 1'b1;
               end
            end
            dss_pkg::DSS_LOCKED: begin
               if (verify_bit != predicted_hold) begin
                  state <= dss_pkg::DSS_HUNT;
               end
            end
            default: state <= dss_pkg::DSS_HUNT;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sync_locked <= 1'b0;
         stall <= 1'b0;
      end else begin
         sync_locked <= state == dss_pkg::DSS_LOCKED;
         stall <= rx_valid && !fifo_in_ready;
      end
   end

   // ****************************************
   // Output buffer
   // ****************************************
   logic fifo_out_valid;
   logic fifo_out_bit;
   dss_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .in_valid(step),
      .in_ready(fifo_in_ready),
      .in_data(rx_bit ^ local_sample),
      .out_valid(fifo_out_valid),
      .out_ready(dsc_ready || !dsc_valid),
      .out_data(fifo_out_bit)
   );

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         dsc_valid <= 1'b0;
         dsc_bit <= 1'b0;
      end else if (dsc_ready || !dsc_valid) begin
         dsc_valid <= fifo_out_valid;
         dsc_bit <= fifo_out_bit;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   a_upper_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
      at_t |=> upper_sample_flop == $past(conveyed)) else $error("upper flop missed bit eight");
   a_seven_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
      at_t1 |=> upper_sample_flop == $past(conveyed) && lower_sample_flop == $past(local_sample))
      else $error("bit seven capture wrong");
   a_mux_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
      at_t |-> mux_valid && mux_bit == (conveyed ^ lower_sample_flop)) else $error("first sample route wrong");
   a_mux_second: assert property (@(posedge sys_clk) disable iff (!rst_n)
      at_t212 && !at_t |-> mux_bit == (upper_sample_flop ^ lower_sample_flop)) else $error("second route wrong");
   a_lower_reload: assert property (@(posedge sys_clk) disable iff (!rst_n)
      at_t213 && !at_t && !at_t1 |=> lower_sample_flop == $past(local_sample)) else $error("lower reload missed");
   a_extract_xor: assert property (@(posedge sys_clk) disable iff (!rst_n)
      at_t1 |=> upper_sample_flop == $past(rx_bit ^ predicted_check_bit)) else $error("extraction wrong");
   a_verify_delay: assert property (@(posedge sys_clk) disable iff (!rst_n)
      mux_valid |=> verify_valid && verify_bit == $past(mux_bit)) else $error("verify not equalised");
   a_dsc_shift: assert property (@(posedge sys_clk) disable iff (!rst_n)
      mux_valid |=> dsc[0] == $past(mux_bit)) else $error("descrambler did not take sample");
   c_first: cover property (@(posedge sys_clk) at_t);
   c_second: cover property (@(posedge sys_clk) at_t212);
   c_locked: cover property (@(posedge sys_clk) sync_locked);
   c_stall: cover property (@(posedge sys_clk) stall);
endmodule
`default_nettype wire

// File: testbench/dss_far_end.sv
/*
 Far-end transmitter model: conveys two scrambler samples per cell.
 Assumes one bit per enabled cycle, driven just after the rising edge,
 and a receiver that takes every offered bit while it runs.
*/
`default_nettype none
module dss_far_end #(
   parameter int CELL_BITS = 424
) (
   // Clock and control
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic en,
   input wire logic corrupt,
   input wire logic flip_pred,
   // Line side
   output logic rx_valid,
   output logic rx_bit,
   output logic bit_at_header_check_bit_eight,
   output logic predicted_check_bit
);
   timeunit 1ns;
   timeprecision 1ps;
   // Mirror of the receiver's free-running local generator
   logic [30:0] lfsr = dss_pkg::PRBS_SEED;
   // Sample stream obeys the feed-forward recurrence; default taps reach bit 3
   logic [3:0] hist = 4'h1;
   logic v_old = 1'b0;
   logic v;
   logic w;
   logic live;
   logic go;
   logic bad;
   logic flip;
   int pos = 0;
   initial begin
      {rx_valid, rx_bit, bit_at_header_check_bit_eight, predicted_check_bit} = 4'h0;
   end
   always @(posedge sys_clk) begin
      // Controls are taken at the edge so bench changes never race the model
      live = rst_n;
      go = en;
      bad = corrupt;
      flip = flip_pred;
      #1;
      rx_valid = live && go;
      bit_at_header_check_bit_eight = live && go && (pos == 0);
      if (!live) begin
         lfsr = dss_pkg::PRBS_SEED;
         hist = 4'h1;
         v_old = 1'b0;
         pos = 0;
         rx_bit = 1'b0;
         predicted_check_bit = 1'b0;
      end else if (!go) begin
         // Idle line toggles so a stale bit never passes for data
         rx_bit = ~rx_bit;
      end else begin
         v = lfsr[30];
         w = ^(hist & dss_pkg::FF_TAPS_DEFAULT[3:0]);
         predicted_check_bit = (pos < 2) ? flip : 1'b0;
         if (pos == 0) begin
            rx_bit = w ^ v_old ^ flip ^ bad;
            hist = {hist[2:0], w};
         end else if (pos == 1) begin
            rx_bit = w ^ v ^ flip ^ bad;
            hist = {hist[2:0], w};
         end else begin
            // Payload descrambles to all ones
            rx_bit = ~v;
         end
         if (pos == CELL_BITS - dss_pkg::SAMPLE_DELAY_BITS) begin
            v_old = v;
         end
         lfsr = {lfsr[29:0], ^(lfsr & dss_pkg::PRBS_TAPS_DEFAULT)};
         pos = (pos == CELL_BITS - 1) ? 0 : pos + 1;
      end
   end
endmodule
`default_nettype wire

// File: testbench/tb_descrambler_sample_sync.sv
/*
 Bench for the descrambler sync block with the far-end model on the line.
 Assumes the far-end model and the design are compiled first.
*/
`default_nettype none
module tb_descrambler_sample_sync;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CELL = 424;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic en = 1'b0;
   logic corrupt = 1'b0;
   logic flip_pred = 1'b0;
   logic dsc_ready = 1'b0;
   logic rx_valid, rx_bit, bit_at_header_check_bit_eight, predicted_check_bit;
   logic dsc_valid, dsc_bit, sync_locked, stall;
   logic seen;
   int fails = 0;
   int checks = 0;
   always #12.5 sys_clk = ~sys_clk;
   dss_far_end #(.CELL_BITS(CELL)) far (.sys_clk(sys_clk), .rst_n(rst_n), .en(en), .corrupt(corrupt),
      .flip_pred(flip_pred), .rx_valid(rx_valid), .rx_bit(rx_bit), .bit_at_header_check_bit_eight(bit_at_header_check_bit_eight),
      .predicted_check_bit(predicted_check_bit));
   dss_sync #(.CELL_BITS(CELL)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .rx_valid(rx_valid),
      .rx_bit(rx_bit), .bit_at_header_check_bit_eight(bit_at_header_check_bit_eight), .predicted_check_bit(predicted_check_bit),
      .dsc_valid(dsc_valid), .dsc_ready(dsc_ready), .dsc_bit(dsc_bit),
      .sync_locked(sync_locked), .stall(stall));
   // ****************************************
   // Helpers
   // ****************************************
   task automatic check_bit(input logic got, input logic exp, input string what);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask
   function automatic logic pick(input int which);
      case (which)
         0: return sync_locked;
         1: return stall;
         default: return dsc_valid;
      endcase
   endfunction
   // Bounded wait; seen tells whether the level showed up in time
   task automatic wait_for(input int which, input logic want, input int limit);
      seen = 1'b0;
      for (int i = 0; i < limit && !seen; i++) begin
         @(posedge sys_clk);
         #1;
         seen = (pick(which) === want);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic do_reset();
      @(posedge sys_clk);
      #1;
      rst_n = 1'b0;
      repeat (10) @(posedge sys_clk);
      #1;
      check_bit(sync_locked | dsc_valid | stall, 1'b0, "outputs not cleared by reset");
      rst_n = 1'b1;
   endtask
   task automatic test_fifo_stall();
      dsc_ready = 1'b0;
      en = 1'b1;
      wait_for(1, 1'b1, 20);
      check_bit(seen, 1'b1, "no stall with sink held off");
      en = 1'b0;
      dsc_ready = 1'b1;
      wait_for(1, 1'b0, 4);
      check_bit(seen, 1'b1, "stall stuck after refusal ended");
      wait_for(2, 1'b0, 20);
      check_bit(seen, 1'b1, "buffer never drained");
   endtask
   task automatic test_acquire();
      int ones;
      en = 1'b1;
      wait_for(0, 1'b1, 60 * CELL);
      check_bit(seen, 1'b1, "sync not acquired");
      // One cell of output: only the two check positions may differ from one
      ones = 0;
      repeat (CELL) begin
         @(posedge sys_clk);
         #1;
         ones += int'(dsc_valid && dsc_bit);
      end
      check_bit(ones >= CELL - 2, 1'b1, "payload not descrambled");
      wait_for(0, 1'b0, 3 * CELL);
      check_bit(seen, 1'b0, "lock lost on clean cells");
   endtask
   // Inverted prediction and inverted check bits convey the same sample
   task automatic test_pred_flip();
      flip_pred = 1'b1;
      wait_for(0, 1'b0, 2 * CELL);
      check_bit(seen, 1'b0, "lock lost with inverted prediction");
      flip_pred = 1'b0;
   endtask
   task automatic test_unlock();
      corrupt = 1'b1;
      wait_for(0, 1'b0, 2 * CELL);
      check_bit(seen, 1'b1, "bad conveyed sample kept lock");
      corrupt = 1'b0;
      wait_for(0, 1'b1, 60 * CELL);
      check_bit(seen, 1'b1, "sync not regained");
   endtask
   initial begin
      do_reset();
      test_fifo_stall();
      // Refused bits leave the line model ahead of the receiver; realign both
      do_reset();
      test_acquire();
      test_pred_flip();
      test_unlock();
      do_reset();
      end_of_test();
   end
   // Worst case is about 130 cells; give generous headroom
   initial begin
      #(200 * CELL * 25);
      fails++;
      end_of_test();
   end
endmodule
`default_nettype wire
